// ### port9_pkg.sv
// Package with register map, field layouts, access kinds and carrier types for port 9.
package port9_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses, low byte lane; high byte lane is plus one
    // ----------------------------------------------------------------
    localparam logic [31:0] PIN_DIRECTION_ADDR = 32'hFFFFF432;
    localparam logic [31:0] PORT_OR_CONTROL_ADDR = 32'hFFFFF452;
    localparam logic [31:0] ALT_FUNCTION_ADDR = 32'hFFFFF472;
    localparam logic [31:0] ALT_EXPANSION_ADDR = 32'hFFFFF712;

    // ----------------------------------------------------------------
    // Implemented pins and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] PIN_DIRECTION_IMPL = 16'hE3C3;
    localparam logic [15:0] PORT_OR_CONTROL_IMPL = 16'hE3C3;
    localparam logic [15:0] ALT_FUNCTION_IMPL = 16'hE3C3;
    localparam logic [15:0] ALT_EXPANSION_IMPL = 16'h20C3;
    localparam logic [15:0] PIN_DIRECTION_RESET = 16'hFFFF;
    localparam logic [15:0] PORT_OR_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] ALT_FUNCTION_RESET = 16'h0000;
    localparam logic [15:0] ALT_EXPANSION_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // Pin numbers
    // ----------------------------------------------------------------
    localparam int PORT_PIN_ZERO = 0;
    localparam int PORT_PIN_ONE = 1;
    localparam int PORT_PIN_SIX = 6;
    localparam int PORT_PIN_SEVEN = 7;
    localparam int PORT_PIN_EIGHT = 8;
    localparam int PORT_PIN_NINE = 9;
    localparam int PORT_PIN_THIRTEEN = 13;
    localparam int PORT_PIN_FOURTEEN = 14;
    localparam int PORT_PIN_FIFTEEN = 15;

    // ----------------------------------------------------------------
    // Access kinds and carrier types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_WORD,
        ACC_BYTE,
        ACC_BIT
    } acc_size_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] wdata;
        acc_size_t size;
    } bus_req_t;

    typedef struct packed {
        logic serial_clock_out;
        logic serial_clock_drive;
        logic serial_data_out;
        logic timer_ch0_compare_out;
        logic timer_ch1_compare_out;
        logic async_transmit_out;
        logic clock_output;
    } periph_out_t;

    typedef struct packed {
        logic ext_interrupt_four;
        logic ext_interrupt_five;
        logic ext_interrupt_six;
        logic serial_clock_in;
        logic serial_data_in;
        logic timer_ch0_capture_in;
        logic timer_ch1_capture_in;
        logic key_return_six;
        logic key_return_seven;
        logic async_receive_in;
    } periph_in_t;

endpackage

// ### port9_alt_route.sv
// Combinational routing of port 9 pins between port logic and alternate peripherals.
module port9_alt_route (
    input wire logic [15:0] direction_i,
    input wire logic [15:0] ctrl_i,
    input wire logic [15:0] fsel_i,
    input wire logic [15:0] fexp_i,
    input wire logic [15:0] port_data_i,
    input wire logic [15:0] pin_in_i,
    input port9_pkg::periph_out_t periph_i,
    output logic [15:0] pin_out_o,
    output logic [15:0] pin_drive_o,
    output port9_pkg::periph_in_t periph_o
);
    import port9_pkg::*;

    function automatic logic [1:0] fpair(input logic [15:0] e, input logic [15:0] s, input int n);
        fpair = {e[n], s[n]};
    endfunction

    // ----------------------------------------------------------------
    // Pin routing
    // ----------------------------------------------------------------
    // A prohibited selection drives the pin low; software must avoid it.
    always_comb begin
        pin_out_o = port_data_i;
        pin_drive_o = ~direction_i & PIN_DIRECTION_IMPL;
        periph_o = '0;
        if (ctrl_i[PORT_PIN_FIFTEEN]) begin // RQ7
            pin_drive_o[PORT_PIN_FIFTEEN] = ~fsel_i[PORT_PIN_FIFTEEN]; // RQ5
            pin_out_o[PORT_PIN_FIFTEEN] = 1'b0;
            periph_o.ext_interrupt_six = fsel_i[PORT_PIN_FIFTEEN] & pin_in_i[PORT_PIN_FIFTEEN];
        end
        if (ctrl_i[PORT_PIN_FOURTEEN]) begin
            pin_drive_o[PORT_PIN_FOURTEEN] = ~fsel_i[PORT_PIN_FOURTEEN]; // RQ5
            pin_out_o[PORT_PIN_FOURTEEN] = 1'b0;
            periph_o.ext_interrupt_five = fsel_i[PORT_PIN_FOURTEEN] & pin_in_i[PORT_PIN_FOURTEEN];
        end
        if (ctrl_i[PORT_PIN_THIRTEEN]) begin
            unique case (fpair(fexp_i, fsel_i, PORT_PIN_THIRTEEN))
                2'h1: begin
                    pin_drive_o[PORT_PIN_THIRTEEN] = 1'b0;
                    periph_o.ext_interrupt_four = pin_in_i[PORT_PIN_THIRTEEN];
                end
                2'h2: begin
                    pin_drive_o[PORT_PIN_THIRTEEN] = 1'b1;
                    pin_out_o[PORT_PIN_THIRTEEN] = periph_i.clock_output;
                end
                default: begin // RQ5
                    pin_drive_o[PORT_PIN_THIRTEEN] = 1'b1;
                    pin_out_o[PORT_PIN_THIRTEEN] = 1'b0;
                end
            endcase
        end
        if (ctrl_i[PORT_PIN_NINE]) begin // RQ8
            if (fsel_i[PORT_PIN_NINE]) begin
                pin_drive_o[PORT_PIN_NINE] = periph_i.serial_clock_drive;
                pin_out_o[PORT_PIN_NINE] = periph_i.serial_clock_out;
                periph_o.serial_clock_in = pin_in_i[PORT_PIN_NINE];
            end else begin // RQ5
                pin_drive_o[PORT_PIN_NINE] = 1'b1;
                pin_out_o[PORT_PIN_NINE] = 1'b0;
            end
        end
        if (ctrl_i[PORT_PIN_EIGHT]) begin // RQ9
            pin_drive_o[PORT_PIN_EIGHT] = 1'b1;
            pin_out_o[PORT_PIN_EIGHT] = fsel_i[PORT_PIN_EIGHT] & periph_i.serial_data_out; // RQ5
        end
        if (ctrl_i[PORT_PIN_SEVEN]) begin // RQ10
            pin_drive_o[PORT_PIN_SEVEN] = 1'b0;
            unique case (fpair(fexp_i, fsel_i, PORT_PIN_SEVEN)) // RQ16
                2'h1: periph_o.serial_data_in = pin_in_i[PORT_PIN_SEVEN];
                2'h2: periph_o.timer_ch0_capture_in = pin_in_i[PORT_PIN_SEVEN];
                2'h3: begin
                    pin_drive_o[PORT_PIN_SEVEN] = 1'b1;
                    pin_out_o[PORT_PIN_SEVEN] = periph_i.timer_ch0_compare_out;
                end
                default: begin // RQ5
                    pin_drive_o[PORT_PIN_SEVEN] = 1'b1;
                    pin_out_o[PORT_PIN_SEVEN] = 1'b0;
                end
            endcase
        end
        if (ctrl_i[PORT_PIN_SIX]) begin // RQ11
            pin_drive_o[PORT_PIN_SIX] = 1'b0;
            unique case (fpair(fexp_i, fsel_i, PORT_PIN_SIX))
                2'h2: periph_o.timer_ch1_capture_in = pin_in_i[PORT_PIN_SIX];
                2'h3: begin
                    pin_drive_o[PORT_PIN_SIX] = 1'b1;
                    pin_out_o[PORT_PIN_SIX] = periph_i.timer_ch1_compare_out;
                end
                default: begin // RQ5
                    pin_drive_o[PORT_PIN_SIX] = 1'b1;
                    pin_out_o[PORT_PIN_SIX] = 1'b0;
                end
            endcase
        end
        if (ctrl_i[PORT_PIN_ONE]) begin // RQ12
            pin_drive_o[PORT_PIN_ONE] = 1'b0;
            unique case (fpair(fexp_i, fsel_i, PORT_PIN_ONE))
                2'h1: periph_o.key_return_seven = pin_in_i[PORT_PIN_ONE];
                2'h2: begin
                    periph_o.key_return_seven = pin_in_i[PORT_PIN_ONE];
                    periph_o.async_receive_in = pin_in_i[PORT_PIN_ONE];
                end
                default: begin // RQ5
                    pin_drive_o[PORT_PIN_ONE] = 1'b1;
                    pin_out_o[PORT_PIN_ONE] = 1'b0;
                end
            endcase
        end
        if (ctrl_i[PORT_PIN_ZERO]) begin // RQ15
            unique case (fpair(fexp_i, fsel_i, PORT_PIN_ZERO)) // RQ17
                2'h1: begin
                    pin_drive_o[PORT_PIN_ZERO] = 1'b0;
                    periph_o.key_return_six = pin_in_i[PORT_PIN_ZERO];
                end
                2'h2: begin
                    pin_drive_o[PORT_PIN_ZERO] = 1'b1;
                    pin_out_o[PORT_PIN_ZERO] = periph_i.async_transmit_out;
                end
                default: begin // RQ5
                    pin_drive_o[PORT_PIN_ZERO] = 1'b1;
                    pin_out_o[PORT_PIN_ZERO] = 1'b0;
                end
            endcase
        end
    end

endmodule // port9_alt_route

// ### port9_pin_mode_select.sv
// Port 9 direction, mode-control and function-select registers with pin routing.
// Function
// RQ1 - Word-wide direction register, zero means output.
// RQ2 - Direction register bytes accessible as byte or bit.
// RQ3 - Word-wide mode register picks port or alternate.
// RQ4 - Mode register bytes accessible as byte or bit.
// RQ5 - Control mode with select bits zero: undefined output.
// RQ6 - Software sets function bits before mode bit.
// RQ7 - Pin fifteen alternate is interrupt input six.
// RQ8 - Pin nine alternate is serial clock, bidirectional.
// RQ9 - Pin eight alternate is serial data output.
// RQ10 - Pin seven alternate: serial input or timer zero.
// RQ11 - Pin six alternate: timer one capture/compare.
// RQ12 - Pin one alternate: key return, async receive.
// RQ13 - Word-wide function-select register with expansion register.
// RQ14 - Function-select bytes accessible as byte or bit.
// RQ15 - Pin zero alternate chosen by select bits.
// RQ16 - Pin seven pair decode: input, capture, compare.
// RQ17 - Pin zero pair decode: key return, transmit.
// RQ18 - Unimplemented bits ignore writes, fixed readback.
// RQ19 - Reset clears mode and function-select registers.
module port9_pin_mode_select (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input port9_pkg::bus_req_t req_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] port_data_i,
    input wire logic [15:0] pin_in_i,
    input port9_pkg::periph_out_t periph_i,
    output logic [15:0] rdata_o,
    output logic [15:0] pin_out_o,
    output logic [15:0] pin_oe_n_o,
    output logic [15:0] direction_o,
    output logic [15:0] ctrl_mode_o,
    output port9_pkg::periph_in_t periph_o
);
    import port9_pkg::*;

    // ----------------------------------------------------------------
    // Access helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input bus_req_t r, input logic [31:0] base);
        hit = (r.addr[31:1] == base[31:1]) && !(r.size == ACC_WORD && r.addr[0]);
    endfunction

    function automatic logic [15:0] lane_mask(input bus_req_t r);
        logic [3:0] idx;
        idx = {r.addr[0], r.wdata[2:0]};
        unique case (r.size)
            ACC_WORD: lane_mask = 16'hFFFF;
            ACC_BYTE: lane_mask = r.addr[0] ? 16'hFF00 : 16'h00FF;
            ACC_BIT: lane_mask = 16'h0001 << idx;
            default: lane_mask = 16'h0000;
        endcase
    endfunction

    function automatic logic [15:0] lane_data(input bus_req_t r);
        unique case (r.size)
            ACC_WORD: lane_data = r.wdata;
            ACC_BYTE: lane_data = {r.wdata[7:0], r.wdata[7:0]};
            default: lane_data = {16{r.wdata[3]}};
        endcase
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input bus_req_t r,
                                          input logic [15:0] impl);
        logic [15:0] m;
        m = lane_mask(r) & impl;
        merge = (old & ~m) | (lane_data(r) & m);
    endfunction

    function automatic logic [15:0] lane_read(input logic [15:0] v, input bus_req_t r);
        logic [3:0] idx;
        idx = {r.addr[0], r.wdata[2:0]};
        unique case (r.size)
            ACC_WORD: lane_read = v;
            ACC_BYTE: lane_read = {8'h00, r.addr[0] ? v[15:8] : v[7:0]};
            ACC_BIT: lane_read = {15'h0000, v[idx]};
            default: lane_read = 16'h0000;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [15:0] direction;
    logic [15:0] ctrl;
    logic [15:0] fsel;
    logic [15:0] fexp;
    logic [15:0] next_direction;
    logic [15:0] next_ctrl;
    logic [15:0] next_fsel;
    logic [15:0] next_fexp;
    logic [15:0] next_rdata;
    logic [15:0] dir_view;

    // Unimplemented direction bits read as one, the others as stored.
    assign dir_view = direction | ~PIN_DIRECTION_IMPL;

    always_comb begin
        next_direction = direction;
        next_ctrl = ctrl;
        next_fsel = fsel;
        next_fexp = fexp;
        next_rdata = 16'h0000;
        if (wr_i) begin
            if (hit(req_i, PIN_DIRECTION_ADDR)) begin // RQ1 RQ2
                next_direction = merge(direction, req_i, PIN_DIRECTION_IMPL); // RQ18
            end
            if (hit(req_i, PORT_OR_CONTROL_ADDR)) begin // RQ3 RQ4
                next_ctrl = merge(ctrl, req_i, PORT_OR_CONTROL_IMPL); // RQ18
            end
            if (hit(req_i, ALT_FUNCTION_ADDR)) begin // RQ13 RQ14
                next_fsel = merge(fsel, req_i, ALT_FUNCTION_IMPL); // RQ18
            end
            if (hit(req_i, ALT_EXPANSION_ADDR)) begin
                next_fexp = merge(fexp, req_i, ALT_EXPANSION_IMPL);
            end
        end
        if (rd_i) begin
            if (hit(req_i, PIN_DIRECTION_ADDR)) begin // RQ2
                next_rdata = lane_read(dir_view, req_i);
            end else if (hit(req_i, PORT_OR_CONTROL_ADDR)) begin // RQ4
                next_rdata = lane_read(ctrl, req_i);
            end else if (hit(req_i, ALT_FUNCTION_ADDR)) begin // RQ14
                next_rdata = lane_read(fsel, req_i);
            end else if (hit(req_i, ALT_EXPANSION_ADDR)) begin
                next_rdata = lane_read(fexp, req_i);
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            direction <= PIN_DIRECTION_RESET;
            ctrl <= PORT_OR_CONTROL_RESET; // RQ19
            fsel <= ALT_FUNCTION_RESET; // RQ19
            fexp <= ALT_EXPANSION_RESET;
            rdata_o <= 16'h0000;
        end else begin
            direction <= next_direction;
            ctrl <= next_ctrl;
            fsel <= next_fsel;
            fexp <= next_fexp;
            rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Pin routing and output registers
    // ----------------------------------------------------------------
    logic [15:0] next_pin_out;
    logic [15:0] next_pin_drive;
    periph_in_t next_periph;

    port9_alt_route u_route (
        .direction_i(direction),
        .ctrl_i(ctrl),
        .fsel_i(fsel),
        .fexp_i(fexp),
        .port_data_i(port_data_i),
        .pin_in_i(pin_in_i),
        .periph_i(periph_i),
        .pin_out_o(next_pin_out),
        .pin_drive_o(next_pin_drive),
        .periph_o(next_periph)
    );

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_out_o <= 16'h0000;
            pin_oe_n_o <= 16'hFFFF;
            direction_o <= 16'hFFFF;
            ctrl_mode_o <= 16'h0000;
            periph_o <= '0;
        end else begin
            pin_out_o <= next_pin_out;
            pin_oe_n_o <= ~next_pin_drive;
            direction_o <= dir_view;
            ctrl_mode_o <= ctrl;
            periph_o <= next_periph;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_dir_word_write: assert property ( // RQ1
        @(posedge core_clk_i) disable iff (rst_i)
        (wr_i && req_i.size == ACC_WORD && req_i.addr == PIN_DIRECTION_ADDR)
        |=> dir_view == ($past(req_i.wdata) | ~PIN_DIRECTION_IMPL))
        else $error("Direction word write not stored.");

    a_dir_high_byte: assert property ( // RQ2
        @(posedge core_clk_i) disable iff (rst_i)
        (wr_i && req_i.size == ACC_BYTE && req_i.addr == PIN_DIRECTION_ADDR + 32'h1)
        |=> direction[7:0] == $past(direction[7:0]))
        else $error("High byte write disturbed low byte.");

    a_ctrl_read_back: assert property ( // RQ3
        @(posedge core_clk_i) disable iff (rst_i)
        (rd_i && req_i.size == ACC_WORD && req_i.addr == PORT_OR_CONTROL_ADDR && !wr_i)
        |=> rdata_o == $past(ctrl))
        else $error("Mode register readback wrong.");

    a_ctrl_bit_write: assert property ( // RQ4
        @(posedge core_clk_i) disable iff (rst_i)
        (wr_i && req_i.size == ACC_BIT && req_i.addr == PORT_OR_CONTROL_ADDR
         && req_i.wdata[2:0] == 3'h7)
        |=> ctrl[7] == $past(req_i.wdata[3]) && ctrl[6:0] == $past(ctrl[6:0]))
        else $error("Mode bit write wrong.");

    a_fsel_byte_read: assert property ( // RQ14
        @(posedge core_clk_i) disable iff (rst_i)
        (rd_i && req_i.size == ACC_BYTE && req_i.addr == ALT_FUNCTION_ADDR + 32'h1)
        |=> rdata_o == {8'h00, $past(fsel[15:8])})
        else $error("Function-select high byte read wrong.");

    a_unimpl_bits: assert property ( // RQ18
        @(posedge core_clk_i) disable iff (rst_i)
        1'b1 |-> (ctrl & ~PORT_OR_CONTROL_IMPL) == 16'h0000
        && (fsel & ~ALT_FUNCTION_IMPL) == 16'h0000 && (direction_o & 16'h1C3C) == 16'h1C3C)
        else $error("Unimplemented bits not fixed.");

    a_port_mode_drive: assert property ( // RQ1
        @(posedge core_clk_i) disable iff (rst_i)
        (!ctrl[8] && !direction[8]) |=> !pin_oe_n_o[8] && pin_out_o[8] == $past(port_data_i[8]))
        else $error("Port mode output not driven.");

    a_pin15_irq: assert property ( // RQ7
        @(posedge core_clk_i) disable iff (rst_i)
        (ctrl[15] && fsel[15]) |=> pin_oe_n_o[15] && periph_o.ext_interrupt_six == $past(pin_in_i[15]))
        else $error("Pin fifteen interrupt route wrong.");

    a_pin8_serial_out: assert property ( // RQ9
        @(posedge core_clk_i) disable iff (rst_i)
        (ctrl[8] && fsel[8]) |=> !pin_oe_n_o[8] && pin_out_o[8] == $past(periph_i.serial_data_out))
        else $error("Pin eight serial output wrong.");

    a_pin7_compare: assert property ( // RQ16
        @(posedge core_clk_i) disable iff (rst_i)
        (ctrl[7] && fexp[7] && fsel[7])
        |=> !pin_oe_n_o[7] && pin_out_o[7] == $past(periph_i.timer_ch0_compare_out))
        else $error("Pin seven compare output wrong.");

    a_pin0_transmit: assert property ( // RQ17
        @(posedge core_clk_i) disable iff (rst_i)
        (ctrl[0] && fexp[0] && !fsel[0])
        |=> !pin_oe_n_o[0] && pin_out_o[0] == $past(periph_i.async_transmit_out))
        else $error("Pin zero transmit output wrong.");

    a_undef_select: assert property ( // RQ5
        @(posedge core_clk_i) disable iff (rst_i)
        (ctrl[6] && !fexp[6]) |=> !pin_oe_n_o[6] && !pin_out_o[6])
        else $error("Prohibited select not driven low.");

    a_pin9_clock: assert property ( // RQ8
        @(posedge core_clk_i) disable iff (rst_i)
        (ctrl[9] && fsel[9]) |=> pin_oe_n_o[9] == !$past(periph_i.serial_clock_drive)
        && periph_o.serial_clock_in == $past(pin_in_i[9]))
        else $error("Pin nine serial clock route wrong.");

    a_pin1_receive: assert property ( // RQ12
        @(posedge core_clk_i) disable iff (rst_i)
        (ctrl[1] && fexp[1] && !fsel[1]) |=> pin_oe_n_o[1]
        && periph_o.async_receive_in == $past(pin_in_i[1]))
        else $error("Pin one receive route wrong.");

endmodule // port9_pin_mode_select

// ### port9_far_side.sv
// Far-side model of port 9: external pin drivers and the alternate peripherals.
module port9_far_side (
    input wire logic core_clk_i,
    input wire logic [15:0] pin_out_i,
    input wire logic [15:0] pin_oe_n_i,
    output logic [15:0] pin_in_o,
    output port9_pkg::periph_out_t periph_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import port9_pkg::*;
    logic [15:0] ext;
    integer seed = 32'h681D;
    initial begin
        ext = 16'h0000;
        periph_o = '0;
    end
    // The outside world and the peripherals take a new random level every cycle.
    always @(posedge core_clk_i) begin
        ext <= 16'($random(seed));
        periph_o <= periph_out_t'(7'($random(seed)));
    end
    // A pin that the block drives reads back its own level.
    assign pin_in_o = (pin_oe_n_i & ext) | (~pin_oe_n_i & pin_out_i);
endmodule // port9_far_side

// ### tb_top.sv
// Self-checking testbench for the port 9 mode and function registers.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import port9_pkg::*;
    logic core_clk_i, rst_i, wr_i, rd_i, ev;
    bus_req_t req;
    logic [15:0] pdat, pin_in, rdata, pout, poe_n, dir_o, mode_o, e_d, e_v, e_g, e_m;
    periph_out_t pper;
    periph_in_t pin_per, e_pi;
    logic [15:0] rg [4];
    logic [15:0] impl [4];
    logic [15:0] rstv [4];
    logic [31:0] base [4];
    integer seed = 32'h681D;
    int failures, n_tests, n, r, i;
    logic [31:0] a;
    acc_size_t s;

    port9_pin_mode_select i_port9_pin_mode_select (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .req_i(req), .wr_i(wr_i), .rd_i(rd_i), .port_data_i(pdat), .pin_in_i(pin_in),
        .periph_i(pper), .rdata_o(rdata), .pin_out_o(pout), .pin_oe_n_o(poe_n),
        .direction_o(dir_o), .ctrl_mode_o(mode_o), .periph_o(pin_per));
    port9_far_side i_port9_far_side (.core_clk_i(core_clk_i), .pin_out_i(pout),
        .pin_oe_n_i(poe_n), .pin_in_o(pin_in), .periph_o(pper));

    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic int find(input logic [31:0] ad);
        for (int k = 0; k < 4; k++) if (ad[31:1] === base[k][31:1]) return k;
        return -1;
    endfunction

    function automatic logic [2:0] pr(input int p);
        return {rg[1][p], rg[3][p], rg[2][p]};
    endfunction

    task automatic wr(input logic [31:0] ad, input acc_size_t sz, input logic [15:0] d);
        int k;
        logic [15:0] m, v;
        @(posedge core_clk_i);
        req <= '{ad, d, sz};
        wr_i <= 1'b1;
        pdat <= 16'($random(seed));
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        k = find(ad);
        m = 16'h0000;
        v = d;
        case (sz)
            ACC_WORD: m = ad[0] ? 16'h0000 : 16'hFFFF;
            ACC_BYTE: begin
                m = ad[0] ? 16'hFF00 : 16'h00FF;
                v = {d[7:0], d[7:0]};
            end
            default: begin
                m = 16'h0001 << {ad[0], d[2:0]};
                v = {16{d[3]}};
            end
        endcase
        if (k >= 0) rg[k] = (rg[k] & ~(m & impl[k])) | (v & m & impl[k]);
    endtask

    task automatic rd(input logic [31:0] ad, input acc_size_t sz);
        int k;
        logic [15:0] e;
        @(posedge core_clk_i);
        req <= '{ad, 16'h0000, sz};
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        k = find(ad);
        e = 16'h0000;
        if (k >= 0 && sz == ACC_WORD && !ad[0]) e = rg[k];
        if (k >= 0 && sz == ACC_BYTE) e = ad[0] ? {8'h00, rg[k][15:8]} : {8'h00, rg[k][7:0]};
        if (k >= 0 && sz == ACC_BIT) e = {15'h0000, rg[k][{ad[0], 3'h0}]};
        #1;
        chk("rdata", e, rdata);
    endtask

    // ----------------------------------------------------------------
    // Pin routing model and per-cycle comparison
    // ----------------------------------------------------------------
    always @(negedge core_clk_i) begin
        ev = !rst_i;
        {e_g, e_m} = {rg[0], rg[1]};
        e_d = 16'h0000;
        e_v = 16'h0000;
        for (n = 0; n < 16; n++) begin
            if (!rg[1][n]) begin
                e_d[n] = !rg[0][n];
                e_v[n] = pdat[n];
            end else begin
                e_d[n] = 1'b1;
                case (n)
                    15, 14: if (pr(n) == 3'b101) e_d[n] = 1'b0;
                    13: if (pr(n) == 3'b101) e_d[n] = 1'b0;
                        else if (pr(n) == 3'b110) e_v[n] = pper.clock_output;
                    9: if (rg[2][9]) {e_d[n], e_v[n]} = {pper.serial_clock_drive,
                        pper.serial_clock_out};
                    8: if (rg[2][8]) e_v[n] = pper.serial_data_out;
                    7: if (pr(n) == 3'b101 || pr(n) == 3'b110) e_d[n] = 1'b0;
                        else if (pr(n) == 3'b111) e_v[n] = pper.timer_ch0_compare_out;
                    6: if (pr(n) == 3'b110) e_d[n] = 1'b0;
                        else if (pr(n) == 3'b111) e_v[n] = pper.timer_ch1_compare_out;
                    1: if (pr(n) == 3'b101 || pr(n) == 3'b110) e_d[n] = 1'b0;
                    0: if (pr(n) == 3'b101) e_d[n] = 1'b0;
                        else if (pr(n) == 3'b110) e_v[n] = pper.async_transmit_out;
                    default: ;
                endcase
            end
        end
        e_pi = '0;
        e_pi.ext_interrupt_six = pr(15) == 3'b101 && pin_in[15];
        e_pi.ext_interrupt_five = pr(14) == 3'b101 && pin_in[14];
        e_pi.ext_interrupt_four = pr(13) == 3'b101 && pin_in[13];
        e_pi.serial_clock_in = pr(9) == 3'b101 && pin_in[9];
        e_pi.serial_data_in = pr(7) == 3'b101 && pin_in[7];
        e_pi.timer_ch0_capture_in = pr(7) == 3'b110 && pin_in[7];
        e_pi.timer_ch1_capture_in = pr(6) == 3'b110 && pin_in[6];
        e_pi.key_return_six = pr(0) == 3'b101 && pin_in[0];
        e_pi.key_return_seven = (pr(1) == 3'b101 || pr(1) == 3'b110) && pin_in[1];
        e_pi.async_receive_in = pr(1) == 3'b110 && pin_in[1];
    end

    always @(posedge core_clk_i) begin
        #1;
        if (ev && !rst_i) begin
            chk("direction", e_g, dir_o);
            chk("ctrl_mode", e_m, mode_o);
            chk("oe_n", ~e_d & impl[0], poe_n & impl[0]);
            chk("pin_out", e_v & e_d & impl[0], pout & e_d & impl[0]);
            chk("periph", 16'(e_pi), 16'(pin_per));
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        #200000;
        failures++;
        end_sim;
    end

    initial begin
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        req = '0;
        pdat = 16'h0000;
        ev = 1'b0;
        failures = 0;
        n_tests = 0;
        base = '{PIN_DIRECTION_ADDR, PORT_OR_CONTROL_ADDR, ALT_FUNCTION_ADDR, ALT_EXPANSION_ADDR};
        impl = '{PIN_DIRECTION_IMPL, PORT_OR_CONTROL_IMPL, ALT_FUNCTION_IMPL, ALT_EXPANSION_IMPL};
        rstv = '{PIN_DIRECTION_RESET, PORT_OR_CONTROL_RESET, ALT_FUNCTION_RESET,
            ALT_EXPANSION_RESET};
        rg = rstv;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 4; i++) rd(base[i], ACC_WORD);
        rd(32'hFFFFF400, ACC_WORD);
        rd(base[0] + 32'h1, ACC_WORD);
        repeat (80) begin
            r = $unsigned($random(seed)) % 4;
            a = base[r] + ($unsigned($random(seed)) % 2);
            s = acc_size_t'($unsigned($random(seed)) % 3);
            wr(a, s, 16'($random(seed)));
            rd(a, (s == ACC_WORD) ? ACC_WORD : ACC_BYTE);
            rd(a, ACC_BIT);
        end
        for (i = 0; i < 4; i++) begin
            wr(base[3], ACC_WORD, i[1] ? 16'hFFFF : 16'h0000);
            wr(base[2], ACC_WORD, i[0] ? 16'hFFFF : 16'h0000);
            wr(base[0], ACC_WORD, 16'($random(seed)));
            wr(base[1], ACC_WORD, 16'hFFFF);
            repeat (16) @(posedge core_clk_i);
            wr(base[1] + 32'h1, ACC_BIT, 16'h0000);
            repeat (8) @(posedge core_clk_i);
        end
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        rg = rstv;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 4; i++) rd(base[i], ACC_WORD);
        repeat (4) @(posedge core_clk_i);
        end_sim;
    end
endmodule // tb_top
